// file: hw/gmpp_mac_end.sv
// gmpp_mac_end: mac end of the gmii/mii data port
// assumes a user on core_clk_i offers transmit beats and takes receive beats,
// and the phy end makes tx_clk and rx_clk
`timescale 1ns/100ps
`default_nettype none
`include "gmpp_defines.svh"

module gmpp_mac_end (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    gmpp_if.mac                        link,
    input  wire gmpp_pkg::gmpp_speed_t speed_i,
    input  wire gmpp_pkg::gmpp_byte_t  tx_data_i,
    input  wire logic                  tx_valid_i,
    input  wire logic                  tx_err_i,
    output logic                       tx_take_o,
    output gmpp_pkg::gmpp_byte_t       rx_data_o,
    output logic                       rx_valid_o,
    output logic                       rx_err_o,
    output logic                       col_o,
    output logic                       crs_o,
    input  wire logic                  mgmt_drive_i,
    input  wire logic                  mgmt_bit_i,
    output logic                       mgmt_bit_o,
    output logic                       mgmt_bit_valid_o
);
    import gmpp_pkg::*;

    // ======================================================================
    // speed decode and gigabit clock
    // ======================================================================
    logic       is_gig;
    logic [7:0] gcnt;
    logic       gtx_q;
    logic       g_wrap;
    logic       gtx_fall;

    assign is_gig   = (speed_i == GMPP_SPD_1000);
    assign g_wrap   = (gcnt >= 8'(`GMPP_HALF_1000) - 8'h01);
    assign gtx_fall = g_wrap & gtx_q & is_gig;

    // gigabit clock runs free while at gigabit so the phy sees every beat
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gcnt  <= 8'h00;
            gtx_q <= 1'b0;
        end else if (!is_gig) begin
            gcnt  <= 8'h00;
            gtx_q <= 1'b0;
        end else if (g_wrap) begin
            gcnt  <= 8'h00;
            gtx_q <= ~gtx_q;
        end else begin
            gcnt  <= gcnt + 8'h01;
        end
    end

    // ======================================================================
    // transmit launch
    // ======================================================================
    logic       tcs1;
    logic       tcs2;
    logic       tcs3;
    logic       launch;
    gmpp_byte_t txd_q;
    logic       tx_en_q;
    logic       tx_er_q;

    // mii launch follows the phy clock rise, a full period before its capture at the next rise
    assign launch = is_gig ? gtx_fall : (tcs2 & ~tcs3);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tcs1      <= 1'b0;
            tcs2      <= 1'b0;
            tcs3      <= 1'b0;
            txd_q     <= 8'h00;
            tx_en_q   <= 1'b0;
            tx_er_q   <= 1'b0;
            tx_take_o <= 1'b0;
        end else begin
            tcs1      <= link.tx_clk;
            tcs2      <= tcs1;
            tcs3      <= tcs2;
            tx_take_o <= launch & tx_valid_i;
            if (launch) begin
                txd_q   <= ~tx_valid_i ? 8'h00 :
                           is_gig ? tx_data_i : (tx_data_i & `GMPP_NIBBLE_MASK);
                tx_en_q <= tx_valid_i;
                tx_er_q <= tx_valid_i & tx_err_i;
            end
        end
    end

    // ======================================================================
    // receive sampling
    // ======================================================================
    logic [12:0] rs1;
    logic [12:0] rs2;
    logic        rclk_s3;
    logic        rx_rise;

    // clock and data pass equal sync depth so their alignment is kept
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rs1     <= 13'h0000;
            rs2     <= 13'h0000;
            rclk_s3 <= 1'b0;
        end else begin
            rs1     <= {link.crs, link.col, link.rx_er, link.rx_dv, link.rxd, link.rx_clk};
            rs2     <= rs1;
            rclk_s3 <= rs2[0];
        end
    end

    assign rx_rise = rs2[0] & ~rclk_s3;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_err_o   <= 1'b0;
            col_o      <= 1'b0;
            crs_o      <= 1'b0;
        end else begin
            rx_valid_o <= rx_rise & rs2[9];
            rx_err_o   <= rx_rise & rs2[9] & rs2[10];
            col_o      <= rs2[11];
            crs_o      <= rs2[12];
            if (rx_rise) begin
                rx_data_o <= is_gig ? rs2[8:1] : {4'h0, rs2[4:1]};
            end
        end
    end

    // ======================================================================
    // management clock and data
    // ======================================================================
    logic [7:0] mcnt;
    logic       mdc_q;
    logic       m_wrap;
    logic       mdio_s1;
    logic       mdio_s2;
    logic       mac_mdio_q;
    logic       mac_mdio_oe_n_q;

    assign m_wrap = (mcnt >= 8'(`GMPP_MDC_HALF) - 8'h01);

    // data changes on the falling edge and is read on the rising edge
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mcnt             <= 8'h00;
            mdc_q            <= 1'b0;
            mdio_s1          <= 1'b1;
            mdio_s2          <= 1'b1;
            mac_mdio_q       <= 1'b1;
            mac_mdio_oe_n_q  <= 1'b1;
            mgmt_bit_o       <= 1'b1;
            mgmt_bit_valid_o <= 1'b0;
        end else begin
            mdio_s1          <= link.mdio;
            mdio_s2          <= mdio_s1;
            mgmt_bit_valid_o <= m_wrap & ~mdc_q;
            mcnt             <= m_wrap ? 8'h00 : mcnt + 8'h01;
            if (m_wrap) begin
                mdc_q <= ~mdc_q;
            end
            if (m_wrap & mdc_q) begin
                mac_mdio_q      <= mgmt_bit_i;
                mac_mdio_oe_n_q <= ~mgmt_drive_i;
            end
            if (m_wrap & ~mdc_q) begin
                mgmt_bit_o <= mdio_s2;
            end
        end
    end

    // ======================================================================
    // pins out
    // ======================================================================
    assign link.gtx_clk       = gtx_q;
    assign link.txd           = txd_q;
    assign link.tx_en         = tx_en_q;
    assign link.tx_er         = tx_er_q;
    assign link.mdc           = mdc_q;
    assign link.mac_mdio      = mac_mdio_q;
    assign link.mac_mdio_oe_n = mac_mdio_oe_n_q;

endmodule // gmpp_mac_end
`default_nettype wire

// file: hw/gmpp_phy_end.sv
// gmpp_phy_end: transceiver end of the gmii/mii data port
// assumes a line model on core_clk_i feeds receive beats and takes transmit beats,
// and the mac end drives gtx_clk from its own divider at gigabit speed
//
// Notes on behaviour
// - gigabit transmit captured on mac gigabit clock
// - mii modes: phy makes transmit clock, samples
// - transmit clock unused and idle at gigabit
// - transmit error ignored at ten megabit
// - mac enables transmit only with valid data
// - mac sends eight transmit data lanes at gigabit, four in mii
// - phy sends eight receive data lanes at gigabit, four in mii
// - receive valid marks every decoded data beat
// - receive error flags errors inside frame
// - receive clock per speed, outputs timed
// - collision shown in half duplex only
// - carrier sense shown in half duplex only
// - straps captured at reset, then held
// - management clock plus shared data line
`timescale 1ns/100ps
`default_nettype none
`include "gmpp_defines.svh"

module gmpp_phy_end (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    gmpp_if.phy                        link,
    input  wire gmpp_pkg::gmpp_speed_t speed_i,
    input  wire logic                  full_duplex_i,
    input  wire gmpp_pkg::gmpp_byte_t  line_rx_data_i,
    input  wire logic                  line_rx_valid_i,
    input  wire logic                  line_rx_err_i,
    input  wire logic                  line_col_i,
    input  wire logic                  line_crs_i,
    output logic                       line_rx_take_o,
    output gmpp_pkg::gmpp_byte_t       line_tx_data_o,
    output logic                       line_tx_valid_o,
    output logic                       line_tx_err_o,
    input  wire logic [5:0]            strap_pins_i,
    output logic [5:0]                 strap_o,
    output logic                       strap_done_o,
    output logic                       mgmt_bit_o,
    output logic                       mgmt_bit_valid_o
);
    import gmpp_pkg::*;

    // ======================================================================
    // speed decode
    // ======================================================================
    logic       is_gig;
    logic       is_ten;
    logic [7:0] half_cnt;

    // one speed input chooses both clock rate and lane width
    assign is_gig   = (speed_i == GMPP_SPD_1000);
    assign is_ten   = (speed_i == GMPP_SPD_10);
    assign half_cnt = is_gig ? 8'(`GMPP_HALF_1000) :
                      (speed_i == GMPP_SPD_100) ? 8'(`GMPP_HALF_100) :
                      8'(`GMPP_HALF_10);

    // ======================================================================
    // gigabit capture on the mac clock
    // ======================================================================
    logic       gtx_rst_s1;
    logic       gtx_rst_n;
    gmpp_byte_t g_txd;
    logic       g_en;
    logic       g_er;
    logic       g_tgl;

    // reset release is synchronised so the first gtx edge is clean
    always_ff @(posedge link.gtx_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gtx_rst_s1 <= 1'b0;
            gtx_rst_n  <= 1'b0;
        end else begin
            gtx_rst_s1 <= 1'b1;
            gtx_rst_n  <= gtx_rst_s1;
        end
    end

    // every gtx rise takes one beat; the toggle tells the core a beat is held
    always_ff @(posedge link.gtx_clk or negedge gtx_rst_n) begin
        if (!gtx_rst_n) begin
            g_txd <= 8'h00;
            g_en  <= 1'b0;
            g_er  <= 1'b0;
            g_tgl <= 1'b0;
        end else begin
            g_txd <= link.txd;
            g_en  <= link.tx_en;
            g_er  <= link.tx_er;
            g_tgl <= ~g_tgl;
        end
    end

    // ======================================================================
    // crossings into the core domain
    // ======================================================================
    logic       tgl_s1;
    logic       tgl_s2;
    logic       tgl_s3;
    logic [9:0] txs1;
    logic [9:0] txs2;
    logic       gig_beat;

    // held beat stays put for a whole gtx period, longer than the toggle sync
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            txs1   <= 10'h000;
            txs2   <= 10'h000;
        end else begin
            tgl_s1 <= g_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            txs1   <= {link.tx_er, link.tx_en, link.txd};
            txs2   <= txs1;
        end
    end

    assign gig_beat = (tgl_s2 ^ tgl_s3) & is_gig;

    // ======================================================================
    // mii transmit clock
    // ======================================================================
    logic [7:0] tx_cnt;
    logic       tx_clk_q;
    logic       tx_wrap;
    logic       mii_rise;

    assign tx_wrap  = (tx_cnt >= half_cnt - 8'h01);
    assign mii_rise = tx_wrap & ~tx_clk_q & ~is_gig;

    // held low at gigabit, where the mac clock is the only timing reference
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_cnt   <= 8'h00;
            tx_clk_q <= 1'b0;
        end else if (is_gig) begin
            tx_cnt   <= 8'h00;
            tx_clk_q <= 1'b0;
        end else if (tx_wrap) begin
            tx_cnt   <= 8'h00;
            tx_clk_q <= ~tx_clk_q;
        end else begin
            tx_cnt   <= tx_cnt + 8'h01;
        end
    end

    // ======================================================================
    // transmit beat to the line
    // ======================================================================
    logic       tx_beat;
    gmpp_byte_t beat_data;
    logic       beat_en;
    logic       beat_er;

    assign tx_beat   = is_gig ? gig_beat : mii_rise;
    assign beat_data = is_gig ? g_txd : {4'h0, txs2[3:0]};
    assign beat_en   = is_gig ? g_en : txs2[8];
    assign beat_er   = (is_gig ? g_er : txs2[9]) & ~is_ten;

    // data lanes only mean something while enable is high
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_tx_valid_o <= 1'b0;
            line_tx_err_o   <= 1'b0;
            line_tx_data_o  <= 8'h00;
        end else begin
            line_tx_valid_o <= tx_beat & beat_en;
            line_tx_err_o   <= tx_beat & beat_er;
            if (tx_beat) begin
                line_tx_data_o <= beat_data;
            end
        end
    end

    // ======================================================================
    // receive clock and outputs
    // ======================================================================
    logic [7:0] rx_cnt;
    logic       rx_clk_q;
    logic       rx_wrap;
    logic       rx_fall;
    gmpp_byte_t rxd_q;
    logic       rx_dv_q;
    logic       rx_er_q;
    logic       col_q;
    logic       crs_q;
    gmpp_byte_t rx_lane;

    assign rx_wrap = (rx_cnt >= half_cnt - 8'h01);
    assign rx_fall = rx_wrap & rx_clk_q;
    assign rx_lane = is_gig ? line_rx_data_i
                            : (line_rx_data_i & `GMPP_NIBBLE_MASK);

    // receive clock runs at every speed, rate set by the resolved speed
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_cnt   <= 8'h00;
            rx_clk_q <= 1'b0;
        end else if (rx_wrap) begin
            rx_cnt   <= 8'h00;
            rx_clk_q <= ~rx_clk_q;
        end else begin
            rx_cnt   <= rx_cnt + 8'h01;
        end
    end

    // outputs change with the falling clock so they are settled at its rise
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_q          <= 8'h00;
            rx_dv_q        <= 1'b0;
            rx_er_q        <= 1'b0;
            col_q          <= 1'b0;
            crs_q          <= 1'b0;
            line_rx_take_o <= 1'b0;
        end else begin
            line_rx_take_o <= rx_fall;
            if (rx_fall) begin
                rxd_q   <= line_rx_valid_i ? rx_lane : 8'h00;
                rx_dv_q <= line_rx_valid_i;
                rx_er_q <= line_rx_valid_i & line_rx_err_i;
                col_q   <= ~full_duplex_i & line_col_i;
                crs_q   <= ~full_duplex_i & line_crs_i;
            end
        end
    end

    // ======================================================================
    // straps
    // ======================================================================
    logic [5:0] strap_s1;
    logic [5:0] strap_s2;
    logic [1:0] strap_cnt;

    // pins settle through the sync pair before the one capture after release
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_s1     <= 6'h00;
            strap_s2     <= 6'h00;
            strap_cnt    <= 2'h0;
            strap_o      <= 6'h00;
            strap_done_o <= 1'b0;
        end else begin
            strap_s1 <= strap_pins_i;
            strap_s2 <= strap_s1;
            if (!strap_done_o) begin
                if (strap_cnt == 2'(`GMPP_STRAP_SETTLE)) begin
                    strap_o      <= strap_s2;
                    strap_done_o <= 1'b1;
                end else begin
                    strap_cnt <= strap_cnt + 2'h1;
                end
            end
        end
    end

    // ======================================================================
    // management line
    // ======================================================================
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic phy_mdio_q;
    logic phy_mdio_oe_n_q;

    // register set is absent, so this end only listens and never drives
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdc_s1           <= 1'b0;
            mdc_s2           <= 1'b0;
            mdc_s3           <= 1'b0;
            mdio_s1          <= 1'b1;
            mdio_s2          <= 1'b1;
            mgmt_bit_o       <= 1'b1;
            mgmt_bit_valid_o <= 1'b0;
            phy_mdio_q       <= 1'b1;
            phy_mdio_oe_n_q  <= 1'b1;
        end else begin
            mdc_s1           <= link.mdc;
            mdc_s2           <= mdc_s1;
            mdc_s3           <= mdc_s2;
            mdio_s1          <= link.mdio;
            mdio_s2          <= mdio_s1;
            mgmt_bit_valid_o <= mdc_s2 & ~mdc_s3;
            phy_mdio_q       <= 1'b1;
            phy_mdio_oe_n_q  <= 1'b1;
            if (mdc_s2 & ~mdc_s3) begin
                mgmt_bit_o <= mdio_s2;
            end
        end
    end

    // ======================================================================
    // pins out
    // ======================================================================
    assign link.tx_clk        = tx_clk_q;
    assign link.rx_clk        = rx_clk_q;
    assign link.rxd           = rxd_q;
    assign link.rx_dv         = rx_dv_q;
    assign link.rx_er         = rx_er_q;
    assign link.col           = col_q;
    assign link.crs           = crs_q;
    assign link.phy_mdio      = phy_mdio_q;
    assign link.phy_mdio_oe_n = phy_mdio_oe_n_q;

endmodule // gmpp_phy_end
`default_nettype wire

// file: shared/gmpp_defines.svh
// gmpp_defines.svh: timing counts and field widths for the gmii/mii port pair
// assumes both ends run their core logic from a 100 MHz core_clk_i
`ifndef GMPP_DEFINES_SVH
`define GMPP_DEFINES_SVH

// ==========================================================================
// line rates, in kHz as the standards name them
`define GMPP_F1000_KHZ    125000
`define GMPP_F100_KHZ     25000
`define GMPP_F10_KHZ      2500

// ==========================================================================
// half periods of the derived link clocks, in core cycles
// gigabit is scaled down so a divider can make it; the 125:25:2.5 ratio holds
`define GMPP_HALF_1000    2
`define GMPP_HALF_100     (`GMPP_HALF_1000 * `GMPP_F1000_KHZ / `GMPP_F100_KHZ)
`define GMPP_HALF_10      (`GMPP_HALF_1000 * `GMPP_F1000_KHZ / `GMPP_F10_KHZ)
`define GMPP_MDC_HALF     4

// ==========================================================================
// straps and lanes
`define GMPP_STRAP_W      6
`define GMPP_STRAP_SETTLE 2
`define GMPP_NIBBLE_MASK  8'h0f

`endif

// file: shared/gmpp_if.sv
// gmpp_if: the pins between the mac end and the phy end
// assumes the testbench instantiates it and hooks both ends to it
`timescale 1ns/100ps
`default_nettype none

interface gmpp_if;
    import gmpp_pkg::*;

    // ======================================================================
    // transmit, receive and status pins
    logic       gtx_clk;
    logic       tx_clk;
    gmpp_byte_t txd;
    logic       tx_en;
    logic       tx_er;
    logic       rx_clk;
    gmpp_byte_t rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col;
    logic       crs;

    // ======================================================================
    // management pins; the shared data line is resolved here, pulled up
    logic       mdc;
    logic       mac_mdio;
    logic       mac_mdio_oe_n;
    logic       phy_mdio;
    logic       phy_mdio_oe_n;
    logic       mdio;

    assign mdio = !mac_mdio_oe_n ? mac_mdio : (!phy_mdio_oe_n ? phy_mdio : 1'b1);

    modport phy (
        input  gtx_clk, txd, tx_en, tx_er, mdc, mdio,
        output tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs, phy_mdio, phy_mdio_oe_n
    );

    modport mac (
        output gtx_clk, txd, tx_en, tx_er, mdc, mac_mdio, mac_mdio_oe_n,
        input  tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs, mdio
    );

endinterface
`default_nettype wire

// file: shared/gmpp_pkg.sv
// gmpp_pkg: types shared by both ends of the gmii/mii port
// assumes the speed is resolved elsewhere and handed in on the core clock
`default_nettype none
package gmpp_pkg;

    // ======================================================================
    // resolved link speed
    typedef enum logic [1:0] {
        GMPP_SPD_10,
        GMPP_SPD_100,
        GMPP_SPD_1000
    } gmpp_speed_t;

    // one data beat on the parallel lanes
    typedef logic [7:0] gmpp_byte_t;

endpackage
`default_nettype wire

// file: tb/gmii_mii_phy_mac_port_tb_top.sv
// gmii_mii_phy_mac_port_tb_top: mac end and phy end joined by the pin interface
// assumes a 100 MHz core clock; speed and duplex move only under reset
`timescale 1ns/100ps
`default_nettype none
`include "gmpp_defines.svh"
module gmii_mii_phy_mac_port_tb_top;
    import gmpp_pkg::*;
    logic clk = 0, rst_n = 0, fd = 0, tv = 0, te = 0, rv = 0, re = 0, lc = 0, ls = 0;
    logic md = 0, mb = 0, tk, ltv, lte, ltk, rxv, rxe, co, cs, sd, pb, pv, mmb;
    gmpp_speed_t spd = GMPP_SPD_10;
    gmpp_byte_t td = '0, rd = '0, ltd, rxo;
    logic [5:0] sp = '0, so;
    int n_mismatch = 0, total_checks = 0;
    gmpp_if lk ();
    initial forever #5 clk = ~clk;
    // ====
    gmpp_phy_end i_gmpp_phy_end (.core_clk_i(clk), .rst_n_i(rst_n), .link(lk), .speed_i(spd),
        .full_duplex_i(fd), .line_rx_data_i(rd), .line_rx_valid_i(rv), .line_rx_err_i(re),
        .line_col_i(lc), .line_crs_i(ls), .line_rx_take_o(ltk), .line_tx_data_o(ltd),
        .line_tx_valid_o(ltv), .line_tx_err_o(lte), .strap_pins_i(sp), .strap_o(so),
        .strap_done_o(sd), .mgmt_bit_o(pb), .mgmt_bit_valid_o(pv));
    gmpp_mac_end i_gmpp_mac_end (.core_clk_i(clk), .rst_n_i(rst_n), .link(lk), .speed_i(spd),
        .tx_data_i(td), .tx_valid_i(tv), .tx_err_i(te), .tx_take_o(tk), .rx_data_o(rxo),
        .rx_valid_o(rxv), .rx_err_o(rxe), .col_o(co), .crs_o(cs), .mgmt_drive_i(md),
        .mgmt_bit_i(mb), .mgmt_bit_o(mmb), .mgmt_bit_valid_o());
    gmpp_checker i_gmpp_checker (.core_clk_i(clk), .rst_n_i(rst_n), .speed_i(spd),
        .full_duplex_i(fd), .gtx_clk(lk.gtx_clk), .tx_clk(lk.tx_clk), .tx_en(lk.tx_en),
        .tx_er(lk.tx_er), .rx_clk(lk.rx_clk), .rx_dv(lk.rx_dv), .rx_er(lk.rx_er),
        .col(lk.col), .crs(lk.crs), .txd(lk.txd), .rxd(lk.rxd));
    // ====
    task automatic chk(string n, logic [7:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    // bounded wait; 10M beats take 200 cycles, so 3000 is ample
    task automatic wt(ref logic s);
        @(negedge clk);
        for (int i = 0; i < 3000 && s !== 1'b1; i++) @(negedge clk);
        if (s !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic rst(gmpp_speed_t s);
        rst_n = 0;
        spd = s;
        fd = s == GMPP_SPD_100;
        sp = 6'h2d;
        repeat (3) @(negedge clk);
        rst_n = 1;
        wt(sd);
        sp = 6'h12;
        repeat (4) @(negedge clk);
        chk("strap", {2'h0, so}, 8'h2d);
        $display("reset test end");
    endtask
    task automatic tx(gmpp_byte_t d, logic e);
        td = d;
        tv = 1;
        te = e;
        wt(tk);
        tv = 0;
        wt(ltv);
        chk("txd", ltd, mii() ? d & `GMPP_NIBBLE_MASK : d);
        chk("txer", {7'h0, lte}, {7'h0, e && spd != GMPP_SPD_10});
        $display("tx test end");
    endtask
    // line also raises collision and carrier; only half duplex may pass them
    task automatic rx(gmpp_byte_t d, logic e);
        rd = d;
        rv = 1;
        re = e;
        lc = 1;
        ls = 1;
        wt(ltk);
        rv = 0;
        re = 0;
        wt(rxv);
        chk("rxd", rxo, mii() ? d & `GMPP_NIBBLE_MASK : d);
        chk("rxer", {7'h0, rxe}, {7'h0, e});
        chk("colcrs", {6'h0, co, cs}, fd ? 8'h0 : 8'h3);
        lc = 0;
        ls = 0;
        $display("rx test end");
    endtask
    // second mdc rise is the first one certain to see the new level
    task automatic mg(logic dr, logic b);
        md = dr;
        mb = b;
        wt(pv);
        wt(pv);
        chk("mdio", {7'h0, pb}, {7'h0, dr ? b : 1'b1});
        // the mac samples the same rise three cycles earlier and holds until the next
        chk("mdio mac", {7'h0, mmb}, {7'h0, dr ? b : 1'b1});
        $display("mgmt test end");
    endtask
    function automatic logic mii();
        return spd != GMPP_SPD_1000;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ====
    initial begin
        for (int s = 0; s < 3; s++) begin
            rst(gmpp_speed_t'(s));
            tx(8'ha5, 1'b1);
            tx(8'h3c, 1'b0);
            rx(8'h96, 1'b1);
            rx(8'h5a, 1'b0);
        end
        mg(1'b1, 1'b0);
        mg(1'b0, 1'b0);
        conclude();
    end
endmodule // gmii_mii_phy_mac_port_tb_top
`default_nettype wire

// file: tb/gmpp_checker.sv
// gmpp_checker: pin rules on the link between the two ends
// assumes speed and duplex change only while reset is held
`timescale 1ns/100ps
`default_nettype none
module gmpp_checker (
    input wire logic                  core_clk_i, rst_n_i, full_duplex_i,
    input wire gmpp_pkg::gmpp_speed_t speed_i,
    input wire logic                  gtx_clk, tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er,
    input wire logic                  col, crs,
    input wire gmpp_pkg::gmpp_byte_t  txd, rxd
);
    import gmpp_pkg::*;
    // ====
    // one core domain; every pin leaves a flop, so core sampling is clean
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire mii_mode = speed_i != GMPP_SPD_1000;
    a_gtx_parked: assert property (mii_mode [*4] |-> !gtx_clk)
        else $error("gtx clock runs in mii");
    a_txclk_parked: assert property (!mii_mode [*4] |-> !tx_clk)
        else $error("tx clock runs at gigabit");
    a_txclk_half: assert property ($rose(tx_clk) && speed_i == GMPP_SPD_100 |->
        ##9 tx_clk ##1 !tx_clk) else $error("tx clock half period");
    a_rx_half: assert property ($rose(rx_clk) && !mii_mode |-> ##1 rx_clk ##1 !rx_clk)
        else $error("rx clock half period");
    a_rx_steady: assert property (!$fell(rx_clk) |-> $stable(rxd) && $stable(rx_dv))
        else $error("rx pins moved off the fall");
    a_fd_quiet: assert property (full_duplex_i [*4] |-> !col && !crs)
        else $error("col or crs in full duplex");
    a_txd_nibble: assert property (mii_mode [*4] |-> txd[7:4] == 4'h0)
        else $error("upper tx lanes used in mii");
    a_rx_er_dv: assert property (rx_er |-> rx_dv)
        else $error("rx error without valid");
    // ====
    cover property (tx_en && tx_er);
    cover property ($rose(rx_dv) && mii_mode);
    cover property ($rose(col));
endmodule // gmpp_checker
`default_nettype wire
